// *** trcp_pkg.sv ***
// package for the reload/capture/pwm timer: register map, field positions, mode codes
// assumes apb with 32-bit data, one register per aligned word
package trcp_pkg;
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_MODE    = 12'h004;
	localparam logic [11:0] ADDR_MODE2   = 12'h008;
	localparam logic [11:0] ADDR_COUNT   = 12'h00C;
	localparam logic [11:0] ADDR_RELOAD  = 12'h010;
	localparam logic [11:0] ADDR_STATUS  = 12'h014;
	// control_reg bit positions
	localparam int C_OVF   = 7;
	localparam int C_EXF   = 6;
	localparam int C_B5    = 5;
	localparam int C_B4    = 4;
	localparam int C_FEN   = 3;
	localparam int C_RUN   = 2;
	localparam int C_CT    = 1;
	localparam int C_CPRL  = 0;
	// mode_reg bit positions
	localparam int M_SPL   = 7;
	localparam int M_LX12  = 6;
	localparam int M_REN   = 5;
	localparam int M_X12   = 4;
	localparam int M_RUNL  = 3;
	localparam int M_RLC   = 2;
	localparam int M_OE    = 1;
	localparam int M_MS0   = 0;
	// mode_reg_second bit positions
	localparam int S_LCS   = 7;
	localparam int S_IGN   = 6;
	localparam int S_FAS   = 5;
	localparam int S_CKS   = 4;
	localparam int S_MS1   = 3;
	localparam int S_SELHI = 2;
	localparam logic [7:0]  BYTE_MAX  = 8'hFF;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	localparam logic [15:0] WORD_MAX  = 16'hFFFF;
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [3:0]  DIV12     = 4'hB;
	typedef enum logic [2:0] {
		TRCP_M_RELOAD0 = 3'b000,
		TRCP_M_RELOAD1 = 3'b001,
		TRCP_M_CAPT    = 3'b010,
		TRCP_M_CAPTZ   = 3'b011,
		TRCP_M_PWM     = 3'b100
	} trcp_mode_t;
endpackage

// *** trcp_evt_if.sv ***
// event bundle between the edge detector and the timer core
// assumes one clock domain (pclk)
`timescale 1ns/10ps
`default_nettype none
interface trcp_evt_if;
	logic [2:0] sel;
	logic       fall_en;
	logic       rise_en;
	logic       edge_event_set;
	modport det  (input sel, input fall_en, input rise_en, output edge_event_set);
	modport core (output sel, output fall_en, output rise_en, input edge_event_set);
endinterface
`default_nettype wire

// *** trcp_edge.sv ***
// edge detector on the selected one of eight external inputs
// assumes inputs synchronous to pclk
`timescale 1ns/10ps
`default_nettype none
module trcp_edge
	import trcp_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// candidate inputs
	input  wire logic [7:0] edge_inputs,
	// event bundle
	trcp_evt_if.det         evt
);
	logic selected_edge_input;
	logic prev_ff;

	assign selected_edge_input = edge_inputs[evt.sel];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_ff <= 1'b0;
		end else begin
			prev_ff <= selected_edge_input;
		end
	end

	assign evt.edge_event_set = (evt.fall_en && prev_ff && !selected_edge_input)
		|| (evt.rise_en && !prev_ff && selected_edge_input);

	a_rise_event: assert property (@(posedge pclk) disable iff (!presetn)
		(evt.rise_en && !evt.fall_en && evt.edge_event_set) |-> !$past(selected_edge_input))
		else $error("rise event without low-to-high edge");
endmodule
`default_nettype wire

// *** trcp_top.sv ***
// reload/capture/pwm/clock-out timer with apb register access
// assumes apb master on pclk; external inputs synchronous to pclk
// Functional notes
// - reload mode counts to ffff, sets overflow flag, reloads from reload pair.
// - falling edge enable adds edge-triggered reload in mode 1 and sets external flag.
// - interrupt requested when overflow flag set and not ignored, or external flag set.
// - rising edge enable acts like falling edge enable for rising edges.
// - capture mode copies counter bytes into reload bytes on edge.
// - external flag shares timer interrupt in capture mode.
// - edge input chosen from eight candidates.
// - capture with auto-zero clears counter on edge.
// - split runs two 8-bit counters with own reloads and clocks.
// - run_main gates high, run_low gates low; autoclear on high overflow.
// - split flags set on ff-to-reload rollovers with own gating.
// - exported overflow from 16-bit counter, or low counter in split.
// - flag access select remaps control bits 5 and 4.
// - split modes 1-3 apply reload/zero to both 8-bit counters, capture to the high one only.
// - split pwm: high sets period, low is compare, reloaded on high overflow.
// - pwm drives clock-out pin only with clock-out enable.
// - clock-out mode reloads at overflow and makes 50 percent clock.
// - clock-out rollover still sets overflow flag, ignore bit masks interrupt.
// - split clock-out toggles on low overflow, reloads low from reload_low.
// - split clock-out low rollovers do not raise low interrupt.
// - mode decoded from mode-high, capture/reload, mode-low bits.
// - edge still flags external flag in mode 0.
`timescale 1ns/10ps
`default_nettype none
module trcp_top
	import trcp_pkg::*;
(
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// clock and edge sources
	input  wire logic [7:0]  edge_inputs,
	input  wire logic [7:0]  clock_sources,
	input  wire logic [1:0]  low_clock_sources,
	// outputs
	output logic             clock_out_pin,
	output logic             clock_out_oe,
	output logic             counter_overflow_event,
	output logic             timer_irq
);
	trcp_evt_if evt ();

	logic [7:0]  control_reg_ff;
	logic [7:0]  mode_reg_ff;
	logic [7:0]  mode_reg_second_ff;
	logic [7:0]  count_high_ff, count_low_ff, reload_high_ff, reload_low_ff;
	logic        low_overflow_flag_ff, low_overflow_irq_enable_ff;
	logic        clk_out_ff;
	logic [3:0]  div_ff;
	logic        tick_div12;
	logic        wr, rd_ok;
	trcp_mode_t  mode;
	logic        split, run_main, run_low, ce_main, ce_low, edge_ev;
	logic        ovf16, ovf_h, ovf_l, capt, clk_mode;
	logic [7:0]  nxt_high, nxt_low;
	logic [31:0] nxt_rdata;

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_a);
		return a == ref_a;
	endfunction

	assign wr       = psel && penable && pwrite;
	assign pready   = 1'b1;
	assign rd_ok    = addr_is(paddr, ADDR_CTRL) || addr_is(paddr, ADDR_MODE)
		|| addr_is(paddr, ADDR_MODE2) || addr_is(paddr, ADDR_COUNT)
		|| addr_is(paddr, ADDR_RELOAD) || addr_is(paddr, ADDR_STATUS);
	assign pslverr  = psel && penable && !rd_ok;

	// mode decode
	assign mode = trcp_mode_t'({mode_reg_second_ff[S_MS1], control_reg_ff[C_CPRL],
		mode_reg_ff[M_MS0]});
	assign split    = mode_reg_ff[M_SPL];
	assign run_main = control_reg_ff[C_RUN];
	assign run_low  = mode_reg_ff[M_RUNL];
	assign clk_mode = !control_reg_ff[C_CPRL] && mode_reg_ff[M_OE];

	assign evt.sel     = mode_reg_second_ff[S_SELHI:0];
	assign evt.fall_en = control_reg_ff[C_FEN];
	assign evt.rise_en = mode_reg_ff[M_REN];
	assign edge_ev     = evt.edge_event_set;

	trcp_edge u_edge (
		.pclk        (pclk),
		.presetn     (presetn),
		.edge_inputs (edge_inputs),
		.evt         (evt)
	);

	// divide-by-12 prescaler for the slow clock choices
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_ff <= 4'h0;
		end else begin
			div_ff <= (div_ff == DIV12) ? 4'h0 : div_ff + 4'h1;
		end
	end
	assign tick_div12 = (div_ff == DIV12);

	// clock enables: source 0 and low source 0 are the /12 tick, low source 1 is every cycle, others external strobes
	always_comb begin
		logic [2:0] hs;
		logic [1:0] ls;
		hs = {mode_reg_second_ff[S_CKS], mode_reg_ff[M_X12], control_reg_ff[C_CT]};
		ls = {mode_reg_second_ff[S_LCS], mode_reg_ff[M_LX12]};
		ce_main = run_main && ((hs == 3'h0) ? tick_div12 : clock_sources[hs]);
		ce_low  = split && run_low && ((ls == 2'h0) ? tick_div12
			: (ls == 2'h1) ? 1'b1 : low_clock_sources[ls[0]]);
	end

	assign ovf16 = !split && ce_main && {count_high_ff, count_low_ff} == WORD_MAX;
	assign ovf_h = split && ce_main && count_high_ff == BYTE_MAX;
	assign ovf_l = ce_low && count_low_ff == BYTE_MAX;
	assign capt  = edge_ev && (mode == TRCP_M_CAPT || mode == TRCP_M_CAPTZ);

	// counter next value
	always_comb begin
		nxt_high = count_high_ff;
		nxt_low  = count_low_ff;
		if (!split) begin
			if (ovf16 || (edge_ev && mode == TRCP_M_RELOAD1)) begin
				nxt_high = reload_high_ff;
				nxt_low  = reload_low_ff;
			end else if (capt && mode == TRCP_M_CAPTZ) begin
				nxt_high = BYTE_ZERO;
				nxt_low  = BYTE_ZERO;
			end else if (ce_main) begin
				{nxt_high, nxt_low} = {count_high_ff, count_low_ff} + 16'h0001;
			end
		end else begin
			if (ovf_h || (edge_ev && mode == TRCP_M_RELOAD1)) begin
				nxt_high = reload_high_ff;
			end else if (capt && mode == TRCP_M_CAPTZ) begin
				nxt_high = BYTE_ZERO;
			end else if (ce_main) begin
				nxt_high = count_high_ff + 8'h01;
			end
			if (mode == TRCP_M_PWM) begin
				if (ovf_h) begin
					nxt_low = reload_low_ff;
				end
			end else if (ovf_l || (edge_ev && mode == TRCP_M_RELOAD1)) begin
				nxt_low = reload_low_ff;
			end else if (capt && mode == TRCP_M_CAPTZ) begin
				nxt_low = BYTE_ZERO;
			end else if (ce_low) begin
				nxt_low = count_low_ff + 8'h01;
			end
		end
	end

	// counters: software write wins; hardware update only when no counter write this cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_high_ff <= BYTE_ZERO;
			count_low_ff  <= BYTE_ZERO;
		end else if (wr && addr_is(paddr, ADDR_COUNT)) begin
			count_high_ff <= pwdata[15:8];
			count_low_ff  <= pwdata[7:0];
		end else begin
			count_high_ff <= nxt_high;
			count_low_ff  <= nxt_low;
		end
	end

	// reload/capture pair; capture wins over a write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_high_ff <= BYTE_ZERO;
			reload_low_ff  <= BYTE_ZERO;
		end else if (capt) begin
			reload_high_ff <= count_high_ff;
			reload_low_ff  <= split ? reload_low_ff : count_low_ff;
		end else if (wr && addr_is(paddr, ADDR_RELOAD)) begin
			reload_high_ff <= pwdata[15:8];
			reload_low_ff  <= pwdata[7:0];
		end
	end

	// control register with flags; set wins over software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_reg_ff <= 8'h00;
		end else begin
			if (wr && addr_is(paddr, ADDR_CTRL)) begin
				control_reg_ff <= pwdata[7:0];
				if (mode_reg_second_ff[S_FAS]) begin
					control_reg_ff[C_B5] <= control_reg_ff[C_B5];
					control_reg_ff[C_B4] <= control_reg_ff[C_B4];
				end
			end
			if (ovf16 || ovf_h) begin
				control_reg_ff[C_OVF] <= 1'b1;
			end
			if (edge_ev) begin
				control_reg_ff[C_EXF] <= 1'b1;
			end
		end
	end

	// low overflow flag and enable, reached through bits 5 and 4
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_overflow_flag_ff       <= 1'b0;
			low_overflow_irq_enable_ff <= 1'b0;
		end else begin
			if (wr && addr_is(paddr, ADDR_CTRL) && mode_reg_second_ff[S_FAS]) begin
				low_overflow_flag_ff       <= pwdata[C_B5];
				low_overflow_irq_enable_ff <= pwdata[C_B4];
			end
			if (ovf_l && !(clk_mode && split)) begin
				low_overflow_flag_ff <= 1'b1;
			end
		end
	end

	// mode registers; high overflow may clear run_low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg_ff        <= 8'h00;
			mode_reg_second_ff <= 8'h00;
		end else begin
			if (wr && addr_is(paddr, ADDR_MODE)) begin
				mode_reg_ff <= pwdata[7:0];
			end
			if (wr && addr_is(paddr, ADDR_MODE2)) begin
				mode_reg_second_ff <= pwdata[7:0];
			end
			if (ovf_h && mode_reg_ff[M_RLC]) begin
				mode_reg_ff[M_RUNL] <= 1'b0;
			end
		end
	end

	// clock-out toggle and pwm output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_out_ff <= 1'b0;
		end else if (!mode_reg_ff[M_OE]) begin
			clk_out_ff <= 1'b0;
		end else if (split && mode == TRCP_M_PWM) begin
			clk_out_ff <= nxt_high < nxt_low;
		end else if (clk_mode && (split ? ovf_l : ovf16)) begin
			clk_out_ff <= !clk_out_ff;
		end
	end
	assign clock_out_pin = clk_out_ff;
	assign clock_out_oe  = mode_reg_ff[M_OE];

	assign counter_overflow_event = split ? ovf_l : ovf16;
	assign timer_irq = (control_reg_ff[C_OVF] && !mode_reg_second_ff[S_IGN])
		|| control_reg_ff[C_EXF]
		|| (low_overflow_flag_ff && low_overflow_irq_enable_ff);

	// read mux, registered at setup
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (addr_is(paddr, ADDR_CTRL)) begin
			nxt_rdata[7:0] = control_reg_ff;
			if (mode_reg_second_ff[S_FAS]) begin
				nxt_rdata[C_B5] = low_overflow_flag_ff;
				nxt_rdata[C_B4] = low_overflow_irq_enable_ff;
			end
		end else if (addr_is(paddr, ADDR_MODE)) begin
			nxt_rdata[7:0] = mode_reg_ff;
		end else if (addr_is(paddr, ADDR_MODE2)) begin
			nxt_rdata[7:0] = mode_reg_second_ff;
		end else if (addr_is(paddr, ADDR_COUNT)) begin
			nxt_rdata[15:0] = {count_high_ff, count_low_ff};
		end else if (addr_is(paddr, ADDR_RELOAD)) begin
			nxt_rdata[15:0] = {reload_high_ff, reload_low_ff};
		end else if (addr_is(paddr, ADDR_STATUS)) begin
			nxt_rdata[1:0] = {clk_out_ff, timer_irq};
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= nxt_rdata;
		end
	end

	a_ovf_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
		ovf16 |=> control_reg_ff[C_OVF])
		else $error("overflow did not set flag");
	a_ovf_reloads: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf16 && !wr) |=> {count_high_ff, count_low_ff} == $past({reload_high_ff, reload_low_ff}))
		else $error("no reload on overflow");
	a_edge_sets_exf: assert property (@(posedge pclk) disable iff (!presetn)
		edge_ev |=> control_reg_ff[C_EXF])
		else $error("edge did not set external flag");
	a_irq_flags: assert property (@(posedge pclk) disable iff (!presetn)
		control_reg_ff[C_EXF] |-> timer_irq)
		else $error("external flag without interrupt");
	a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
		(capt && !split) |=> {reload_high_ff, reload_low_ff} == $past({count_high_ff, count_low_ff}))
		else $error("capture value wrong");
	a_autozero: assert property (@(posedge pclk) disable iff (!presetn)
		(capt && !split && mode == TRCP_M_CAPTZ && !ovf16 && !wr) |=> {count_high_ff, count_low_ff} == WORD_ZERO)
		else $error("auto-zero failed");
	a_autoclear_run: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf_h && mode_reg_ff[M_RLC]) |=> !mode_reg_ff[M_RUNL])
		else $error("run_low not cleared");
	a_export_ovf: assert property (@(posedge pclk) disable iff (!presetn)
		split |-> counter_overflow_event == ovf_l)
		else $error("wrong exported overflow");
	a_pin_gated: assert property (@(posedge pclk) disable iff (!presetn)
		!mode_reg_ff[M_OE] |=> !clock_out_pin)
		else $error("clock-out driven while disabled");
	a_clkout_toggle: assert property (@(posedge pclk) disable iff (!presetn)
		(clk_mode && !split && ovf16) |=> clock_out_pin != $past(clock_out_pin))
		else $error("clock-out did not toggle");
	a_ovf_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
		(control_reg_ff[C_OVF] && !(wr && paddr == ADDR_CTRL)) |=> control_reg_ff[C_OVF])
		else $error("overflow flag lost without software clear");
	a_low_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf_l && !mode_reg_ff[M_OE]) |=> low_overflow_flag_ff)
		else $error("low overflow did not set low flag");
	a_pwm_cmp_load: assert property (@(posedge pclk) disable iff (!presetn)
		(split && mode == TRCP_M_PWM && ovf_h && !wr) |=> count_low_ff == $past(reload_low_ff))
		else $error("pwm compare not loaded on high overflow");
	a_ovf_irq_on: assert property (@(posedge pclk) disable iff (!presetn)
		(control_reg_ff[C_OVF] && !mode_reg_second_ff[S_IGN]) |-> timer_irq)
		else $error("unmasked overflow flag without interrupt");

	c_reload: cover property (@(posedge pclk) ovf16);
	c_capture: cover property (@(posedge pclk) capt);
	c_split_low: cover property (@(posedge pclk) ovf_l);
	c_pwm: cover property (@(posedge pclk) split && mode == TRCP_M_PWM && ovf_h);
endmodule
`default_nettype wire

// *** trcp_far.sv ***
// far-side model: candidate edge inputs, count strobes, clock-out pin
// assumes pclk from the bench; strobes last one pclk cycle
`timescale 1ns/10ps
`default_nettype none
module trcp_far (
	// clock
	input  wire logic       pclk,
	// pins toward the timer
	output logic      [7:0] edge_inputs,
	output logic      [7:0] clock_sources,
	output logic      [1:0] low_clock_sources,
	// clock-out pin
	input  wire logic       clock_out_pin,
	input  wire logic       clock_out_oe
);
	logic seen_level;
	// inputs idle high so only a commanded edge reaches the detector
	initial begin
		edge_inputs = 8'hFF;
		clock_sources = 8'h00;
		low_clock_sources = 2'h0;
	end
	// strobe on source index 2 for the main counter, index 0 for the low one
	task automatic tick(input int n, input logic hi, input logic lo);
		repeat (n) begin
			@(posedge pclk);
			clock_sources <= {5'h00, hi, 2'h0};
			low_clock_sources <= {1'b0, lo};
			@(posedge pclk);
			clock_sources <= 8'h00;
			low_clock_sources <= 2'h0;
		end
	endtask
	// edge needs time to pass the detector before anyone looks
	task automatic set_pin(input int idx, input logic v);
		@(posedge pclk);
		edge_inputs[idx] <= v;
		repeat (3) @(posedge pclk);
	endtask
	// an undriven pin is pulled low outside
	assign seen_level = clock_out_oe ? clock_out_pin : 1'b0;
endmodule
`default_nettype wire

// *** tb_top.sv ***
// directed testbench for the timer over apb
// assumes trcp_top and the far-side model trcp_far
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import trcp_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  edge_inputs;
	logic [7:0]  clock_sources;
	logic [1:0]  low_clock_sources;
	logic        clock_out_pin;
	logic        clock_out_oe;
	logic        counter_overflow_event;
	logic        timer_irq;
	logic [31:0] rd;
	logic        err;
	int          error_cnt = 0;
	int          checks = 0;
	int          ev_cnt = 0;
	int          cyc = 0;
	trcp_top u_trcp_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .edge_inputs(edge_inputs), .clock_sources(clock_sources),
		.low_clock_sources(low_clock_sources), .clock_out_pin(clock_out_pin),
		.clock_out_oe(clock_out_oe), .counter_overflow_event(counter_overflow_event),
		.timer_irq(timer_irq));
	trcp_far u_trcp_far (.pclk(pclk), .edge_inputs(edge_inputs),
		.clock_sources(clock_sources), .low_clock_sources(low_clock_sources),
		.clock_out_pin(clock_out_pin), .clock_out_oe(clock_out_oe));
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;
	// tests need well under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (counter_overflow_event === 1'b1) ev_cnt <= ev_cnt + 1;
		if (cyc == 5000) begin
			error_cnt = error_cnt + 1;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait limit here: only the cycle ceiling ends a hung transfer
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp($sformatf("reg %h", a), e, rd);
	endtask
	task automatic pc(input string nm, input logic e, input logic g);
		cmp(nm, 32'(e), 32'(g));
	endtask
	task automatic do_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	initial begin
		int e0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		do_reset();
		for (int i = 0; i < 6; i++) rc(12'(4 * i), 32'h0);
		apb(1'b0, 12'h018, 32'h0);
		pc("slverr", 1'b1, err);
		wr(12'h018, 32'hFFFF_FFFF);
		rc(ADDR_CTRL, 32'h0);
		$display("test reset done");
		// 16-bit reload on overflow
		wr(ADDR_MODE, 32'h10);
		wr(ADDR_RELOAD, 32'h1234);
		wr(ADDR_COUNT, 32'hFFFE);
		wr(ADDR_CTRL, 32'h04);
		e0 = ev_cnt;
		u_trcp_far.tick(2, 1'b1, 1'b0);
		rc(ADDR_COUNT, 32'h1234);
		rc(ADDR_CTRL, 32'h84);
		pc("irq", 1'b1, timer_irq);
		cmp("events", 32'h1, 32'(ev_cnt - e0));
		repeat (20) @(posedge pclk);
		rc(ADDR_CTRL, 32'h84);
		wr(ADDR_CTRL, 32'h04);
		rc(ADDR_CTRL, 32'h04);
		pc("irq", 1'b0, timer_irq);
		$display("test reload done");
		// edge-triggered reload, falling then rising
		wr(ADDR_CTRL, 32'h08);
		wr(ADDR_MODE, 32'h11);
		wr(ADDR_MODE2, 32'h05);
		wr(ADDR_RELOAD, 32'hABCD);
		wr(ADDR_COUNT, 32'h0100);
		u_trcp_far.set_pin(3, 1'b0);
		rc(ADDR_COUNT, 32'h0100);
		rc(ADDR_CTRL, 32'h08);
		u_trcp_far.set_pin(5, 1'b0);
		rc(ADDR_COUNT, 32'hABCD);
		rc(ADDR_CTRL, 32'h48);
		pc("irq", 1'b1, timer_irq);
		wr(ADDR_CTRL, 32'h00);
		wr(ADDR_MODE, 32'h31);
		wr(ADDR_COUNT, 32'h0100);
		u_trcp_far.set_pin(5, 1'b1);
		rc(ADDR_COUNT, 32'hABCD);
		rc(ADDR_CTRL, 32'h40);
		$display("test edge reload done");
		// capture, then capture with zeroing
		wr(ADDR_MODE, 32'h10);
		wr(ADDR_CTRL, 32'h09);
		wr(ADDR_COUNT, 32'h3456);
		u_trcp_far.set_pin(5, 1'b0);
		rc(ADDR_RELOAD, 32'h3456);
		rc(ADDR_CTRL, 32'h49);
		pc("irq", 1'b1, timer_irq);
		wr(ADDR_MODE, 32'h11);
		wr(ADDR_CTRL, 32'h09);
		wr(ADDR_COUNT, 32'h789A);
		u_trcp_far.set_pin(5, 1'b1);
		rc(ADDR_COUNT, 32'h789A);
		u_trcp_far.set_pin(5, 1'b0);
		rc(ADDR_RELOAD, 32'h789A);
		rc(ADDR_COUNT, 32'h0);
		rc(ADDR_CTRL, 32'h49);
		$display("test capture done");
		// mode 0 keeps the count but flags the edge
		wr(ADDR_MODE, 32'h10);
		wr(ADDR_CTRL, 32'h08);
		wr(ADDR_COUNT, 32'h0101);
		u_trcp_far.set_pin(5, 1'b1);
		u_trcp_far.set_pin(5, 1'b0);
		rc(ADDR_COUNT, 32'h0101);
		rc(ADDR_CTRL, 32'h48);
		$display("test mode0 edge done");
		// split counters with autoclear and flag remap
		wr(ADDR_CTRL, 32'h04);
		wr(ADDR_MODE, 32'h9C);
		wr(ADDR_MODE2, 32'hA0);
		wr(ADDR_RELOAD, 32'h1020);
		wr(ADDR_COUNT, 32'hFEFF);
		e0 = ev_cnt;
		u_trcp_far.tick(1, 1'b1, 1'b1);
		rc(ADDR_COUNT, 32'hFF20);
		rc(ADDR_CTRL, 32'h24);
		u_trcp_far.tick(1, 1'b1, 1'b1);
		rc(ADDR_COUNT, 32'h1021);
		rc(ADDR_CTRL, 32'hA4);
		rc(ADDR_MODE, 32'h94);
		cmp("events", 32'h1, 32'(ev_cnt - e0));
		u_trcp_far.tick(1, 1'b0, 1'b1);
		rc(ADDR_COUNT, 32'h1021);
		wr(ADDR_MODE2, 32'hE0);
		wr(ADDR_CTRL, 32'h24);
		pc("irq", 1'b0, timer_irq);
		wr(ADDR_CTRL, 32'h34);
		rc(ADDR_CTRL, 32'h34);
		pc("irq", 1'b1, timer_irq);
		$display("test split done");
		// split pwm: period from high reload, compare from low reload
		wr(ADDR_CTRL, 32'h04);
		wr(ADDR_MODE, 32'h90);
		wr(ADDR_MODE2, 32'h08);
		wr(ADDR_RELOAD, 32'h0003);
		wr(ADDR_COUNT, 32'hFF00);
		u_trcp_far.tick(1, 1'b1, 1'b0);
		rc(ADDR_COUNT, 32'h0003);
		rc(ADDR_CTRL, 32'h84);
		pc("oe", 1'b0, clock_out_oe);
		pc("pin", 1'b0, u_trcp_far.seen_level);
		wr(ADDR_MODE, 32'h92);
		rc(ADDR_MODE, 32'h92);
		pc("pin", 1'b1, u_trcp_far.seen_level);
		u_trcp_far.tick(3, 1'b1, 1'b0);
		rc(ADDR_COUNT, 32'h0303);
		pc("pin", 1'b0, u_trcp_far.seen_level);
		$display("test pwm done");
		// 16-bit clock-out; mid-run reset first
		do_reset();
		rc(ADDR_STATUS, 32'h0);
		pc("pin", 1'b0, clock_out_pin);
		wr(ADDR_MODE2, 32'h40);
		wr(ADDR_RELOAD, 32'hFFFE);
		wr(ADDR_COUNT, 32'hFFFE);
		wr(ADDR_MODE, 32'h12);
		wr(ADDR_CTRL, 32'h04);
		e0 = ev_cnt;
		u_trcp_far.tick(2, 1'b1, 1'b0);
		rc(ADDR_COUNT, 32'hFFFE);
		rc(ADDR_CTRL, 32'h84);
		pc("irq", 1'b0, timer_irq);
		pc("pin", 1'b1, u_trcp_far.seen_level);
		u_trcp_far.tick(2, 1'b1, 1'b0);
		rc(ADDR_STATUS, 32'h0);
		cmp("events", 32'h2, 32'(ev_cnt - e0));
		$display("test clock out done");
		// split clock-out from the low counter
		do_reset();
		wr(ADDR_MODE2, 32'hA0);
		wr(ADDR_CTRL, 32'h10);
		wr(ADDR_RELOAD, 32'h00FF);
		wr(ADDR_COUNT, 32'h00FF);
		wr(ADDR_MODE, 32'h8A);
		e0 = ev_cnt;
		u_trcp_far.tick(1, 1'b0, 1'b1);
		rc(ADDR_COUNT, 32'h00FF);
		rc(ADDR_CTRL, 32'h10);
		pc("irq", 1'b0, timer_irq);
		pc("pin", 1'b1, u_trcp_far.seen_level);
		u_trcp_far.tick(1, 1'b0, 1'b1);
		rc(ADDR_STATUS, 32'h0);
		cmp("events", 32'h2, 32'(ev_cnt - e0));
		$display("test split clock out done");
		test_done();
	end
endmodule
`default_nettype wire
